// [logic/palette_ram_access_port.sv]
// Palette RAM access port: index/data registers and pixel lookup
`timescale 1ns/10ps
`default_nettype none
module palette_ram_access_port
  import palette_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pixel side
  input wire logic pixel_clock_en,
  input wire logic [7:0] pixel_in,
  input wire logic [1:0] pixel_sel,
  output logic [17:0] pixel_colour
);
  // ==========================================
  // Address decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] offs);
    hit = (a[15:2] == offs[15:2]);
  endfunction

  logic idx_hit;
  logic dat_hit;
  logic dat_acc;
  always_comb begin
    idx_hit = hit(reg_addr, PALETTE_INDEX_OFFS); // RULE_01
    dat_hit = hit(reg_addr, PALETTE_DATA_OFFS); // RULE_01
    dat_acc = dat_hit && (reg_wr || reg_rd);
  end

  // Storage slot: extension indices packed after the 256 standard ones
  function automatic logic [8:0] slot_of(input logic [8:0] idx);
    if (idx[8] == 1'b0) begin
      slot_of = idx; // RULE_05
    end else if (idx == CURSOR0_IDX) begin
      slot_of = 9'h100; // RULE_06
    end else if (idx == CURSOR1_IDX) begin
      slot_of = 9'h101; // RULE_06
    end else if (idx == OVERSCAN_IDX) begin
      slot_of = 9'h102; // RULE_06
    end else begin
      // Reserved or unbacked: dropped on write, zero on read
      slot_of = 9'h1FF;
    end
  endfunction

  // ==========================================
  // Index register
  logic [8:0] index_r;
  logic [8:0] index_nxt;
  always_comb begin
    index_nxt = index_r;
    // Load takes priority, data access advances by one
    if (reg_wr && idx_hit) begin
      index_nxt = reg_wdata[INDEX_W-1:0]; // RULE_02 RULE_11
    end else if (dat_acc) begin
      index_nxt = index_r + 9'h001; // RULE_03
    end
  end

  chk_index_idle: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_02
    (!(reg_wr && idx_hit) && !dat_acc) |=> $stable(index_r))
    else $error("index moved without register access");

  // ==========================================
  // Storage
  logic [8:0] pix_slot;
  logic [17:0] host_entry;
  logic [17:0] pix_entry;
  logic [8:0] host_slot;
  logic host_wr;
  always_comb begin
    case (pixel_sel)
      2'h1: pix_slot = slot_of(CURSOR0_IDX);
      2'h2: pix_slot = slot_of(CURSOR1_IDX);
      2'h3: pix_slot = slot_of(OVERSCAN_IDX);
      default: pix_slot = {1'b0, pixel_in};
    endcase
  end

  // ==========================================
  // Host access slot
  // Unbacked indices never write the store; reads of them return ENTRY_RESET
  always_comb begin
    host_slot = slot_of(index_r);
    host_wr = reg_wr && dat_hit && host_slot != 9'h1FF; // RULE_06 RULE_07
  end

  chk_store_slot: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_06
    host_wr |-> host_slot < 9'(RAM_DEPTH))
    else $error("palette write outside storage");

  // Port A serves the host, port B the pixel lookup
  palette_store u_store (
    .mclk(mclk),
    .reset_n(reset_n),
    .wr_en(host_wr), // RULE_07
    .wr_slot(host_slot),
    .wr_data(reg_wdata[ENTRY_W-1:0]), // RULE_07 RULE_11
    .rd_slot_a(host_slot),
    .rd_data_a(host_entry),
    .rd_slot_b(pix_slot),
    .rd_data_b(pix_entry)
  );

  // ==========================================
  // Read data
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  // Read data stand for one cycle only, zero otherwise
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd && idx_hit) begin
      rdata_nxt = {23'h000000, index_r}; // RULE_02 RULE_11
    end else if (reg_rd && dat_hit) begin
      rdata_nxt = {14'h0000, host_entry}; // RULE_07 RULE_11
    end
  end

  chk_rdata_idle: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_11
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not cleared after read cycle");
  chk_unmapped_rd: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_01
    (reg_rd && !idx_hit && !dat_hit) |=> reg_rdata == 32'h00000000)
    else $error("unmapped read returned data");
  chk_reserved_rd: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_06
    (reg_rd && dat_hit && (index_r == 9'h102 || index_r == 9'h103 || index_r > OVERSCAN_IDX))
      |=> reg_rdata == 32'h00000000)
    else $error("reserved entry read returned data");

  // ==========================================
  // Pixel output with hold on palette access
  logic [17:0] colour_r;
  logic [17:0] colour_nxt;
  logic hold_r;
  logic hold_nxt;
  // Hold flag: a data access skips the next pixel update,
  // so the output never shows an entry mid-update
  always_comb begin
    colour_nxt = colour_r;
    hold_nxt = hold_r;
    if (dat_acc) begin
      hold_nxt = 1'b1; // RULE_08
    end
    if (pixel_clock_en) begin
      // Access in the same cycle uses up the hold at once
      if (hold_r || dat_acc) begin
        hold_nxt = 1'b0; // RULE_08
      end else begin
        colour_nxt = pix_entry;
      end
    end
  end

  chk_pixel_lookup: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_05
    (pixel_clock_en && !hold_r && !dat_acc) |=> pixel_colour == $past(pix_entry))
    else $error("pixel output not updated from palette");
  chk_hold_arm: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    (dat_acc && !pixel_clock_en) |=> hold_r)
    else $error("hold not armed by data access");
  chk_held_skip: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    (hold_r && pixel_clock_en) |=> $stable(pixel_colour))
    else $error("held pixel output changed");
  chk_hold_wait: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    (hold_r && !pixel_clock_en) |=> hold_r)
    else $error("hold dropped without pixel clock");

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      index_r <= INDEX_RESET;
      rdata_r <= 32'h00000000;
      colour_r <= ENTRY_RESET;
      hold_r <= 1'b0;
    end else begin
      index_r <= index_nxt;
      rdata_r <= rdata_nxt;
      colour_r <= colour_nxt;
      hold_r <= hold_nxt;
    end
  end

  always_comb begin
    reg_rdata = rdata_r;
    pixel_colour = colour_r;
  end

  // ==========================================
  // Checks
  chk_index_incr: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_03
    dat_acc |=> index_r == $past(index_r) + 9'h001)
    else $error("index did not advance after data access");
  chk_index_load: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_02
    (reg_wr && idx_hit) |=> index_r == $past(reg_wdata[8:0]))
    else $error("index load mismatch");
  chk_index_read: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_11
    (reg_rd && idx_hit) |=> reg_rdata == {23'h000000, $past(index_r)})
    else $error("index readback wrong");
  chk_data_upper: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_07
    reg_rdata[31:18] == 14'h0000)
    else $error("data upper bits not zero");
  chk_write_read: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_07
    (reg_wr && dat_hit && index_r < 9'h100) ##1 (reg_wr && idx_hit
      && reg_wdata[8:0] == $past(index_r)) ##1 (reg_rd && dat_hit)
      |=> reg_rdata[17:0] == $past(reg_wdata[17:0], 3))
    else $error("palette entry readback wrong");
  chk_hold_once: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    (dat_acc && pixel_clock_en) |=> colour_r == $past(colour_r))
    else $error("pixel output not held");
  chk_hold_clear: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    (hold_r && pixel_clock_en && !dat_acc) |=> !hold_r)
    else $error("hold not released");
  chk_quiet_out: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
    !pixel_clock_en |=> colour_r == $past(colour_r))
    else $error("pixel output moved without pixel clock");
endmodule
`default_nettype wire

// [logic/palette_pkg.sv]
// Constants for the palette RAM access port
// How it works
// (RULE_01) Index and data registers, adjacent 32-bit words
// (RULE_02) Index register holds 9-bit index, bits 8:0
// (RULE_03) Index increments after each data access
// (RULE_04) Software reloads index for non-consecutive groups
// (RULE_05) Indices 0h-FFh are 256 standard colours
// (RULE_06) 100h/101h cursor colours, 104h overscan, 102h/103h reserved
// (RULE_07) Data register carries 18-bit entry, bits 17:0
// (RULE_08) Palette output held one extra pixel clock
// (RULE_09) Software loads index before first data access
// (RULE_10) Indices 105h-1FFh and reserved ones unused
// (RULE_11) Reserved upper bits read zero, writes ignored
package palette_pkg;
  // ==========================================
  // Register map
  localparam logic [15:0] PALETTE_INDEX_OFFS = 16'h8370;
  localparam logic [15:0] PALETTE_DATA_OFFS = 16'h8374;
  // ==========================================
  // Field layout
  localparam int INDEX_W = 9;
  localparam int ENTRY_W = 18;
  localparam int STD_ENTRIES = 256;
  localparam int EXT_ENTRIES = 3;
  localparam int RAM_DEPTH = STD_ENTRIES + EXT_ENTRIES;
  localparam logic [8:0] CURSOR0_IDX = 9'h100;
  localparam logic [8:0] CURSOR1_IDX = 9'h101;
  localparam logic [8:0] OVERSCAN_IDX = 9'h104;
  // ==========================================
  // Reset values (every palette entry is also reset to ENTRY_RESET)
  localparam logic [8:0] INDEX_RESET = 9'h000;
  localparam logic [17:0] ENTRY_RESET = 18'h00000;
  // Extra hold of the pixel output, in pixel clocks
  localparam int HOLD_CYCLES = 1;
endpackage

// [logic/palette_store.sv]
// Flip-flop palette storage with one write and two read ports
`timescale 1ns/10ps
`default_nettype none
module palette_store
  import palette_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Write port
  input wire logic wr_en,
  input wire logic [8:0] wr_slot,
  input wire logic [17:0] wr_data,
  // Read ports
  input wire logic [8:0] rd_slot_a,
  output logic [17:0] rd_data_a,
  input wire logic [8:0] rd_slot_b,
  output logic [17:0] rd_data_b
);
  logic [17:0] mem_r [RAM_DEPTH];
  logic [17:0] mem_nxt [RAM_DEPTH];

  genvar g;
  generate
    for (g = 0; g < RAM_DEPTH; g++) begin : g_ent
      always_comb begin
        mem_nxt[g] = mem_r[g];
        if (wr_en && wr_slot == 9'(g)) begin
          mem_nxt[g] = wr_data;
        end
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          mem_r[g] <= ENTRY_RESET;
        end else begin
          mem_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_data_a = (rd_slot_a < 9'(RAM_DEPTH)) ? mem_r[rd_slot_a] : ENTRY_RESET;
    rd_data_b = (rd_slot_b < 9'(RAM_DEPTH)) ? mem_r[rd_slot_b] : ENTRY_RESET;
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the palette RAM access port
`timescale 1ns/10ps
`default_nettype none
module tb;
  import palette_pkg::*;
  // ==========================================
  // Signals
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pixel_clock_en = 1'b0;
  logic [7:0] pixel_in = 8'h00;
  logic [1:0] pixel_sel = 2'h0;
  logic [17:0] pixel_colour;
  int n_errors = 0;
  int samples_checked = 0;
  int mem [512];
  int idx = 0;
  int shown = 0;
  bit held = 1'b0;
  palette_ram_access_port u_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pixel_clock_en(pixel_clock_en), .pixel_in(pixel_in), .pixel_sel(pixel_sel),
    .pixel_colour(pixel_colour));
  always #50 mclk = ~mclk;
  // ==========================================
  // Model and tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic [15:0] a, input logic [31:0] d, input bit w);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  // Entries that really hold data
  function automatic bit live(input int i);
    return i <= 'h101 || i == 'h104;
  endfunction
  task automatic seti(input int i);
    bus(PALETTE_INDEX_OFFS, ($urandom & 32'hFFFFFE00) | i, 1'b1);
    idx = i;
  endtask
  task automatic put(input logic [31:0] d);
    bus(PALETTE_DATA_OFFS, d, 1'b1);
    if (live(idx)) mem[idx] = d[17:0];
    idx = (idx + 1) % 512;
    held = 1'b1;
  endtask
  task automatic get();
    bus(PALETTE_DATA_OFFS, 32'h0, 1'b0);
    check("entry", live(idx) ? mem[idx] : 0, reg_rdata);
    idx = (idx + 1) % 512;
    held = 1'b1;
  endtask
  task automatic pix(input logic [1:0] s);
    int e;
    @(posedge mclk);
    pixel_sel <= s;
    pixel_in <= 8'hF8 + 8'($urandom % 8);
    @(posedge mclk);
    pixel_clock_en <= 1'b1;
    @(posedge mclk);
    pixel_clock_en <= 1'b0;
    #1;
    e = s == 0 ? int'(pixel_in) : s == 1 ? 'h100 : s == 2 ? 'h101 : 'h104;
    if (!held) shown = mem[e];
    held = 1'b0;
    check_colour(18'(shown), pixel_colour);
  endtask
  task automatic check_colour(input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD colour expected %h seen %h", exp, got);
    end
  endtask
  // Back-to-back strobes: data write, index reload, data read
  task automatic chain(input int i, input logic [31:0] d);
    seti(i);
    @(posedge mclk);
    reg_addr <= PALETTE_DATA_OFFS;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    pixel_clock_en <= 1'b1;
    @(posedge mclk);
    reg_addr <= PALETTE_INDEX_OFFS;
    reg_wdata <= ($urandom & 32'hFFFFFE00) | i;
    pixel_clock_en <= 1'b0;
    @(posedge mclk);
    reg_addr <= PALETTE_DATA_OFFS;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    mem[i] = d[17:0];
    check("entry", mem[i], reg_rdata);
    check_colour(18'(shown), pixel_colour);
    idx = i + 1;
    held = 1'b1;
    @(posedge mclk);
    #1;
    check("idle rdata", 32'h00000000, reg_rdata);
  endtask
  // ==========================================
  // Tests
  initial begin
    void'($urandom(32'h418fd147));
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    seti('h0F8);
    bus(PALETTE_INDEX_OFFS, 32'h0, 1'b0);
    check("index", 'h0F8, reg_rdata);
    for (int k = 0; k < 14; k++) put($urandom);
    bus(PALETTE_INDEX_OFFS, 32'h0, 1'b0);
    check("index", idx, reg_rdata);
    seti('h0F8);
    repeat (14) get();
    bus(16'h8378, $urandom, 1'b1);
    bus(16'h8378, 32'h0, 1'b0);
    check("unmapped", 0, reg_rdata);
    bus(PALETTE_INDEX_OFFS, 32'h0, 1'b0);
    check("index", idx, reg_rdata);
    for (int s = 0; s < 4; s++) begin
      seti('h0F8 + s);
      put($urandom);
      pix(2'(s));
      pix(2'(s));
      get();
      pix(2'(s));
    end
    chain('h0F0 + int'($urandom % 8), $urandom);
    pix(2'h0);
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
